// ---- include/flash_guard_pkg.sv ----
// package: constants and carriers for the flash write and erase guard
package flash_guard_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ERASE_CMD_ADDR  = 8'h94;
	localparam logic [7:0] ARM_REG_ADDR    = 8'hb2;
	localparam logic [7:0] PAGE_REG_ADDR   = 8'hb7;
	localparam int         ARM_BIT         = 1;
	localparam int         PAGE_LSB        = 1;
	localparam logic [7:0] MASS_PATTERN    = 8'haa;
	localparam logic [7:0] PAGE_PATTERN    = 8'h55;
	localparam logic [7:0] ERASED_BYTE     = 8'hff;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int         PAGE_BYTES      = 1024;
	localparam int         PAGE_SHIFT      = 10;
	localparam int         ENGINE_WORDS    = 4096;
	localparam int         FLASH_AW        = 18;
	localparam int         BANK_W          = 3;
	localparam int         SMALL_BANK_W    = 2;
	localparam logic [15:0] UPPER_BASE     = 16'h8000;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int         CLK_MHZ         = 100;
	localparam int         WRITE_US        = 42;
	localparam int         ERASE_MS        = 20;
	localparam int         WRITE_CYC       = WRITE_US * CLK_MHZ;
	localparam int         ERASE_CYC       = ERASE_MS * 1000 * CLK_MHZ;
	localparam int         BOOT_CYC        = 60;
	localparam int         CNT_W           = 24;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} store_req_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WRITE = 4'b0010,
		ST_PAGE  = 4'b0100,
		ST_MASS  = 4'b1000
	} seq_state_t;
endpackage

// ---- src/boot_window.sv ----
// module: pre-boot window counter holding the debug port off
`timescale 1ns/1ns
module boot_window (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	output logic      window_out
);
	import flash_guard_pkg::*;

	logic [6:0] count_ff;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_ff <= 7'h00;
		end else if (ce_in && count_ff != 7'(BOOT_CYC)) begin
			count_ff <= count_ff + 7'h01;
		end
	end

	assign window_out = (count_ff != 7'(BOOT_CYC));
endmodule

// ---- src/flash_write_erase_guard.sv ----
// module: flash steering, write/erase sequencing, banking and security lock
// Contract
// - pages are 1024 bytes, erased individually
// - engine code start is page value times 1024
// - steer bit sends data stores to flash
// - steer bit writes ignored while interrupts enabled
// - write during engine run dropped, interrupt raised
// - write pending at pass start skips pass
// - engine-idle interrupt on falling edge
// - write 42 us, page erase 20 ms busy
// - erased bytes read all ones
// - mass erase needs arm then 0xaa
// - mass erase only with debug port enabled
// - page erase needs page then 0x55
// - low 32 KB fixed, upper bank selectable
// - bank field two or three bits wide
// - locked debug port allows only mass erase
// - first 60 cycles block debug port
// - lock clears at reset, writes only set
// - lock released by any reset, mass erase not needed
// - locked page zero refuses erase and write
`timescale 1ns/1ns
module flash_write_erase_guard #(
	parameter int WRITE_CYCLES = flash_guard_pkg::WRITE_CYC,
	parameter int ERASE_CYCLES = flash_guard_pkg::ERASE_CYC,
	parameter bit SMALL_FLASH  = 1'b0
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	input  wire logic                          ce_in,
	input  wire flash_guard_pkg::sfr_req_t     sfr_in,
	input  wire logic                          irq_global_en_in,
	input  wire flash_guard_pkg::store_req_t   store_in,
	input  wire logic [15:0]                   prog_addr_in,
	input  wire logic                          engine_busy_in,
	input  wire logic                          engine_pass_req_in,
	input  wire logic                          debug_port_en_in,
	input  wire logic                          debug_op_req_in,
	input  wire logic                          debug_mass_req_in,
	input  wire logic [flash_guard_pkg::BANK_W-1:0] upper_bank_select_in,
	input  wire logic [7:0]                    engine_code_page_in,
	input  wire logic                          lock_set_in,
	output logic                               flash_write_steer_out,
	output logic                               ram_store_out,
	output logic [flash_guard_pkg::FLASH_AW-1:0] prog_flash_addr_out,
	output logic [flash_guard_pkg::FLASH_AW-1:0] engine_start_out,
	output logic                               engine_pass_go_out,
	output logic                               write_blocked_irq_out,
	output logic                               pass_skipped_irq_out,
	output logic                               engine_idle_irq_out,
	output logic                               flash_busy_out,
	output logic                               flash_we_out,
	output logic [flash_guard_pkg::FLASH_AW-1:0] flash_addr_out,
	output logic [7:0]                         flash_wdata_out,
	output logic                               erase_page_out,
	output logic                               erase_all_out,
	output logic                               code_lock_out,
	output logic                               boot_window_flag_out,
	output logic                               debug_grant_out
);
	import flash_guard_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	seq_state_t            state_ff;
	seq_state_t            nxt_state;
	logic [CNT_W-1:0]      timer_ff;
	logic                  steer_ff;
	logic                  arm_ff;
	logic [6:0]            page_sel_ff;
	logic                  lock_ff;
	logic                  mass_done_ff;
	logic                  eng_busy_d_ff;
	logic                  wr_blk_ff;
	logic                  skip_ff;
	logic                  idle_irq_ff;
	logic                  pass_go_ff;
	logic [FLASH_AW-1:0]   waddr_ff;
	logic [7:0]            wdata_ff;
	logic                  boot_win;
	logic                  sfr_wr;
	logic                  steer_wr;
	logic                  cmd_wr;
	logic                  store_flash;
	logic                  write_ok;
	logic                  mass_ok;
	logic                  page_ok;
	logic                  dbg_mass;
	logic [BANK_W-1:0]     bank;
	logic [FLASH_AW-1:0]   store_addr;

	boot_window u_boot (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.window_out (boot_win)
	);

	// ------------------------------------------------------------
	// address mapping
	// ------------------------------------------------------------
	always_comb begin
		bank = upper_bank_select_in;
		if (SMALL_FLASH) begin
			bank[BANK_W-1] = 1'b0;
		end
	end

	function automatic logic [FLASH_AW-1:0] map_addr(input logic [15:0] a,
		input logic [BANK_W-1:0] b);
		if (a < UPPER_BASE) begin
			map_addr = {3'h0, a[14:0]};
		end else begin
			map_addr = {b, a[14:0]};
		end
	endfunction

	assign store_addr          = map_addr(store_in.addr, bank);
	assign prog_flash_addr_out = map_addr(prog_addr_in, bank);
	assign engine_start_out    = FLASH_AW'({engine_code_page_in, 10'h000});

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	assign sfr_wr   = ce_in && sfr_in.wr;
	assign steer_wr = sfr_wr && sfr_in.addr == ARM_REG_ADDR && !irq_global_en_in;
	assign cmd_wr   = sfr_wr && sfr_in.addr == ERASE_CMD_ADDR;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			steer_ff <= 1'b0;
			arm_ff   <= 1'b0;
		end else if (steer_wr) begin
			steer_ff <= sfr_in.wdata[0];
			arm_ff   <= sfr_in.wdata[ARM_BIT];
		end else if (cmd_wr) begin
			arm_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			page_sel_ff <= 7'h00;
		end else if (sfr_wr && sfr_in.addr == PAGE_REG_ADDR) begin
			page_sel_ff <= sfr_in.wdata[7:PAGE_LSB];
		end
	end

	// ------------------------------------------------------------
	// security lock and debug gate
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_ff <= 1'b0;
		end else if (ce_in && lock_set_in) begin
			lock_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mass_done_ff <= 1'b0;
		end else if (ce_in && state_ff == ST_MASS && timer_ff == '0) begin
			mass_done_ff <= 1'b1;
		end
	end

	// locked debug port keeps only mass erase, nothing in the boot window
	assign debug_grant_out = debug_port_en_in && !boot_win &&
		debug_op_req_in && !lock_ff;
	assign dbg_mass = ce_in && debug_port_en_in && !boot_win && debug_mass_req_in;
	assign boot_window_flag_out = boot_win;
	assign code_lock_out        = lock_ff;

	// ------------------------------------------------------------
	// operation qualification
	// ------------------------------------------------------------
	assign store_flash = store_in.wr && steer_ff;
	assign ram_store_out = store_in.wr && !steer_ff;
	assign flash_write_steer_out = steer_ff;
	assign write_ok = ce_in && store_flash && state_ff == ST_IDLE && !engine_busy_in &&
		!(lock_ff && store_addr[FLASH_AW-1:PAGE_SHIFT] == '0);
	assign mass_ok = (cmd_wr && sfr_in.wdata == MASS_PATTERN && arm_ff &&
		debug_port_en_in) || dbg_mass;
	assign page_ok = cmd_wr && sfr_in.wdata == PAGE_PATTERN &&
		!(lock_ff && page_sel_ff == 7'h00);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (mass_ok) begin
					nxt_state = ST_MASS;
				end else if (page_ok) begin
					nxt_state = ST_PAGE;
				end else if (write_ok) begin
					nxt_state = ST_WRITE;
				end
			end
			ST_WRITE, ST_PAGE, ST_MASS: begin
				if (timer_ff == '0) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= ST_IDLE;
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_ff <= '0;
		end else if (ce_in) begin
			if (state_ff == ST_IDLE) begin
				if (mass_ok || page_ok) begin
					timer_ff <= CNT_W'(ERASE_CYCLES - 1);
				end else if (write_ok) begin
					timer_ff <= CNT_W'(WRITE_CYCLES - 1);
				end
			end else if (timer_ff != '0) begin
				timer_ff <= timer_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			waddr_ff <= '0;
			wdata_ff <= ERASED_BYTE;
		end else if (ce_in && state_ff == ST_IDLE) begin
			if (page_ok) begin
				waddr_ff <= FLASH_AW'({page_sel_ff, 10'h000});
			end else if (write_ok) begin
				waddr_ff <= store_addr;
				wdata_ff <= store_in.wdata;
			end
		end
	end

	assign flash_busy_out  = state_ff != ST_IDLE;
	assign flash_we_out    = state_ff == ST_WRITE;
	assign erase_page_out  = state_ff == ST_PAGE;
	assign erase_all_out   = state_ff == ST_MASS;
	assign flash_addr_out  = waddr_ff;
	assign flash_wdata_out = wdata_ff;

	// ------------------------------------------------------------
	// collision and engine events
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			eng_busy_d_ff <= 1'b0;
			wr_blk_ff     <= 1'b0;
			skip_ff       <= 1'b0;
			idle_irq_ff   <= 1'b0;
			pass_go_ff    <= 1'b0;
		end else if (ce_in) begin
			eng_busy_d_ff <= engine_busy_in;
			wr_blk_ff     <= store_flash && engine_busy_in;
			skip_ff       <= engine_pass_req_in && state_ff == ST_WRITE;
			pass_go_ff    <= engine_pass_req_in && state_ff != ST_WRITE;
			idle_irq_ff   <= eng_busy_d_ff && !engine_busy_in;
		end
	end

	assign write_blocked_irq_out = wr_blk_ff;
	assign pass_skipped_irq_out  = skip_ff;
	assign engine_idle_irq_out   = idle_irq_ff;
	assign engine_pass_go_out    = pass_go_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_mass_cmd;
		ce_in && state_ff == ST_IDLE && cmd_wr && sfr_in.wdata == MASS_PATTERN;
	endsequence

	sequence s_write_go;
		ce_in && state_ff == ST_IDLE && write_ok && !mass_ok && !page_ok;
	endsequence

	sequence s_erase_go;
		ce_in && state_ff == ST_IDLE && (mass_ok || page_ok);
	endsequence

	boot_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		boot_win |-> !debug_grant_out) else $error("debug granted in boot window");
	lock_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(lock_ff) |-> lock_ff) else $error("lock cleared without reset");
	mass_unarmed_a: assert property (@(posedge clk_in) disable iff (rst_in)
		s_mass_cmd ##0 (!arm_ff && !dbg_mass) |=> state_ff != ST_MASS)
		else $error("mass erase without arm");
	mass_debug_a: assert property (@(posedge clk_in) disable iff (rst_in)
		s_mass_cmd ##0 !debug_port_en_in |=> state_ff != ST_MASS)
		else $error("mass erase with debug port off");
	write_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && store_flash && engine_busy_in |=> wr_blk_ff && !flash_we_out)
		else $error("collision write not dropped");
	pass_skip_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && engine_pass_req_in && flash_we_out |=> skip_ff && !engine_pass_go_out)
		else $error("pass not skipped");
	page_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && lock_ff && state_ff == ST_IDLE && cmd_wr && page_sel_ff == 7'h00 &&
		!mass_ok |=> state_ff != ST_PAGE) else $error("locked page zero erased");
	steer_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		irq_global_en_in |=> $stable(steer_ff)) else $error("steer changed with irq on");
	bank_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!prog_addr_in[15] |-> prog_flash_addr_out[FLASH_AW-1:15] == '0)
		else $error("lower bank remapped");
	idle_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && eng_busy_d_ff && !engine_busy_in |=> engine_idle_irq_out)
		else $error("engine idle irq missing");
	write_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
		s_write_go |=> flash_we_out && timer_ff == CNT_W'(WRITE_CYCLES - 1))
		else $error("write busy length wrong");
	erase_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
		s_erase_go |=> (erase_page_out || erase_all_out) &&
		timer_ff == CNT_W'(ERASE_CYCLES - 1)) else $error("erase busy length wrong");
	page_base_a: assert property (@(posedge clk_in) disable iff (rst_in)
		s_erase_go ##0 !mass_ok |=> erase_page_out && flash_addr_out[PAGE_SHIFT-1:0] == '0)
		else $error("page erase base not aligned");
	busy_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		flash_busy_out && timer_ff != '0 |=> flash_busy_out)
		else $error("operation ended early");
	busy_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
		flash_busy_out |=> $stable(flash_addr_out)) else $error("address moved while busy");
	lock_grant_a: assert property (@(posedge clk_in) disable iff (rst_in)
		lock_ff |-> !debug_grant_out) else $error("debug granted while locked");
	start_page_a: assert property (@(posedge clk_in) disable iff (rst_in)
		engine_start_out[PAGE_SHIFT-1:0] == '0 &&
		engine_start_out[FLASH_AW-1:PAGE_SHIFT] == engine_code_page_in)
		else $error("engine start not on page");
	mass_mark_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(mass_done_ff) |-> $past(erase_all_out)) else $error("mass mark without erase");
	steer_route_a: assert property (@(posedge clk_in) disable iff (rst_in)
		store_in.wr && steer_ff |-> !ram_store_out) else $error("steered store hit ram");
	bank_small_a: assert property (@(posedge clk_in) disable iff (rst_in)
		SMALL_FLASH && prog_addr_in[15] |-> !prog_flash_addr_out[FLASH_AW-1])
		else $error("small bank field too wide");
endmodule

// ---- verification/engine_model.sv ----
// engine model: pass requests and busy window of the compute engine
`timescale 1ns/1ns
module engine_model #(
	parameter int BUSY_LEN = 6
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic start_in,
	input  wire logic go_in,
	output logic      busy_out,
	output logic      pass_req_out
);
	int cnt_ff;

	// pass request one cycle after the bench command
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pass_req_out <= 1'b0;
		end else begin
			pass_req_out <= start_in;
		end
	end

	// busy only for a granted pass, idle gap afterwards
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff <= 0;
		end else if (go_in) begin
			cnt_ff <= BUSY_LEN;
		end else if (cnt_ff != 0) begin
			cnt_ff <= cnt_ff - 1;
		end
	end

	assign busy_out = (cnt_ff != 0);
endmodule

// ---- verification/flash_write_erase_guard_tb_top.sv ----
// testbench: flash write and erase guard
`timescale 1ns/1ns
module flash_write_erase_guard_tb_top;
	import flash_guard_pkg::*;
	localparam int WC = 8;
	localparam int EC = 16;
	logic                clk_in, rst_in, irq_en, pr_start, eng_busy, eng_req;
	logic                dbg_en, dbg_op, dbg_mass, lock_set, r, ce;
	sfr_req_t            sfr;
	store_req_t          st;
	logic [15:0]         paddr;
	logic [BANK_W-1:0]   bank;
	logic [7:0]          cpage, fwd;
	logic                steer, ram_st, go, blk, skp, idle, busy, we, epage, eall, lock;
	logic                bwin, grant;
	logic [FLASH_AW-1:0] pfa, estart, faddr, pfa_s;
	int                  n_fail, check_count, n_blk, n_skp, n_idle, n_go, n, b0, s0, i0, g0;

	flash_write_erase_guard #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .sfr_in(sfr),
		.irq_global_en_in(irq_en), .store_in(st), .prog_addr_in(paddr),
		.engine_busy_in(eng_busy), .engine_pass_req_in(eng_req),
		.debug_port_en_in(dbg_en), .debug_op_req_in(dbg_op), .debug_mass_req_in(dbg_mass),
		.upper_bank_select_in(bank), .engine_code_page_in(cpage), .lock_set_in(lock_set),
		.flash_write_steer_out(steer), .ram_store_out(ram_st), .prog_flash_addr_out(pfa),
		.engine_start_out(estart), .engine_pass_go_out(go), .write_blocked_irq_out(blk),
		.pass_skipped_irq_out(skp), .engine_idle_irq_out(idle), .flash_busy_out(busy),
		.flash_we_out(we), .flash_addr_out(faddr), .flash_wdata_out(fwd),
		.erase_page_out(epage), .erase_all_out(eall), .code_lock_out(lock),
		.boot_window_flag_out(bwin), .debug_grant_out(grant));

	flash_write_erase_guard #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC), .SMALL_FLASH(1'b1)) u_small (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .sfr_in(sfr),
		.irq_global_en_in(irq_en), .store_in(st), .prog_addr_in(paddr),
		.engine_busy_in(eng_busy), .engine_pass_req_in(eng_req),
		.debug_port_en_in(dbg_en), .debug_op_req_in(dbg_op), .debug_mass_req_in(dbg_mass),
		.upper_bank_select_in(bank), .engine_code_page_in(cpage), .lock_set_in(lock_set),
		.flash_write_steer_out(), .ram_store_out(), .prog_flash_addr_out(pfa_s),
		.engine_start_out(), .engine_pass_go_out(), .write_blocked_irq_out(),
		.pass_skipped_irq_out(), .engine_idle_irq_out(), .flash_busy_out(),
		.flash_we_out(), .flash_addr_out(), .flash_wdata_out(),
		.erase_page_out(), .erase_all_out(), .code_lock_out(),
		.boot_window_flag_out(), .debug_grant_out());

	engine_model u_eng (.clk_in(clk_in), .rst_in(rst_in), .start_in(pr_start), .go_in(go),
		.busy_out(eng_busy), .pass_req_out(eng_req));

	// ------------------------------------------------------------
	// pulse counters and shared tasks
	// ------------------------------------------------------------
	always @(posedge clk_in) begin
		if (blk === 1'b1) n_blk++;
		if (skp === 1'b1) n_skp++;
		if (idle === 1'b1) n_idle++;
		if (go === 1'b1) n_go++;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		sfr <= '{1'b1, a, d};
		@(posedge clk_in);
		sfr.wr <= 1'b0;
	endtask

	task automatic store(input logic [15:0] a, input logic [7:0] d, output logic rs);
		@(posedge clk_in);
		st <= '{1'b1, a, d};
		#1 rs = ram_st;
		@(posedge clk_in);
		st.wr <= 1'b0;
	endtask

	task automatic pass_cmd();
		@(posedge clk_in);
		pr_start <= 1'b1;
		@(posedge clk_in);
		pr_start <= 1'b0;
	endtask

	task automatic wait_on(input bit eng, input logic v);
		for (int i = 0; i < 60 && (eng ? eng_busy : busy) !== v; i++) begin
			tick();
		end
		if ((eng ? eng_busy : busy) !== v) begin
			n_fail++;
			$display("MISMATCH t=%0t wait ran out", $time);
			tally_and_finish();
		end
	endtask

	task automatic stand(output int k);
		k = 0;
		while (busy === 1'b1 && k < 100) begin
			tick();
			k++;
		end
		if (busy === 1'b1) begin
			n_fail++;
			$display("MISMATCH t=%0t busy ran out", $time);
			tally_and_finish();
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_boot();
		do_reset();
		#1;
		check(lock, 1'b0);
		check(fwd, ERASED_BYTE);
		check(grant, 1'b0);
		n = 0;
		while (bwin === 1'b1 && n < 100) begin
			tick();
			n++;
		end
		check(n, BOOT_CYC);
		if (bwin === 1'b1) begin
			tally_and_finish();
		end
		check(grant, 1'b1);
	endtask

	task automatic s_write();
		store(16'h1234, 8'h11, r);
		check(r, 1'b1);
		sfr_wr(ARM_REG_ADDR, 8'h01);
		tick();
		check(steer, 1'b1);
		@(posedge clk_in);
		irq_en <= 1'b1;
		sfr_wr(ARM_REG_ADDR, 8'h00);
		tick();
		check(steer, 1'b1);
		@(posedge clk_in);
		irq_en <= 1'b0;
		store(16'h1234, 8'h5a, r);
		check(r, 1'b0);
		wait_on(0, 1'b1);
		check(we, 1'b1);
		check(fwd, 8'h5a);
		sfr_wr(PAGE_REG_ADDR, 8'h0a);
		sfr_wr(ERASE_CMD_ADDR, PAGE_PATTERN);
		stand(n);
		check(n + 5, WC);
		tick();
		check(epage, 1'b0);
		check(busy, 1'b0);
	endtask

	task automatic s_collide();
		g0 = n_go;
		i0 = n_idle;
		b0 = n_blk;
		s0 = n_skp;
		pass_cmd();
		wait_on(1, 1'b1);
		check(n_go - g0, 1);
		store(16'h2000, 8'h33, r);
		wait_on(1, 1'b0);
		tick();
		check(idle, 1'b1);
		tick();
		check(n_blk - b0, 1);
		check(busy, 1'b0);
		check(n_idle - i0, 1);
		store(16'h2001, 8'h44, r);
		pass_cmd();
		wait_on(0, 1'b1);
		stand(n);
		check(n_skp - s0, 1);
		check(n_go - g0, 1);
		sfr_wr(ARM_REG_ADDR, 8'h00);
	endtask

	task automatic s_erase();
		sfr_wr(PAGE_REG_ADDR, 8'h0a);
		sfr_wr(ERASE_CMD_ADDR, PAGE_PATTERN);
		wait_on(0, 1'b1);
		check(epage, 1'b1);
		check(faddr, 5 * PAGE_BYTES);
		stand(n);
		check(n + 1, EC);
		@(posedge clk_in);
		dbg_en <= 1'b0;
		sfr_wr(ARM_REG_ADDR, 8'h02);
		sfr_wr(ERASE_CMD_ADDR, MASS_PATTERN);
		repeat (3) tick();
		check(busy, 1'b0);
		@(posedge clk_in);
		dbg_en <= 1'b1;
		sfr_wr(ERASE_CMD_ADDR, MASS_PATTERN);
		repeat (3) tick();
		check(busy, 1'b0);
		@(posedge clk_in);
		lock_set <= 1'b1;
		@(posedge clk_in);
		lock_set <= 1'b0;
		tick();
		check(lock, 1'b1);
		check(grant, 1'b0);
		sfr_wr(PAGE_REG_ADDR, 8'h00);
		sfr_wr(ERASE_CMD_ADDR, PAGE_PATTERN);
		repeat (3) tick();
		check(busy, 1'b0);
		sfr_wr(ARM_REG_ADDR, 8'h01);
		store(16'h0010, 8'h00, r);
		repeat (3) tick();
		check(busy, 1'b0);
		sfr_wr(ARM_REG_ADDR, 8'h02);
		sfr_wr(ERASE_CMD_ADDR, MASS_PATTERN);
		wait_on(0, 1'b1);
		check(eall, 1'b1);
		stand(n);
		check(lock, 1'b1);
		do_reset();
		tick();
		check(lock, 1'b0);
		@(posedge clk_in);
		dbg_mass <= 1'b1;
		@(posedge clk_in);
		dbg_mass <= 1'b0;
		tick();
		check(busy, 1'b0);
	endtask

	task automatic s_map();
		for (int b = 0; b < 8; b++) begin
			@(posedge clk_in);
			bank <= 3'(b);
			paddr <= 16'h8abc;
			tick();
			check(pfa, {3'(b), 15'h0abc});
			check(pfa_s, {1'b0, 2'(b), 15'h0abc});
			@(posedge clk_in);
			paddr <= 16'h1234;
			tick();
			check(pfa, 18'h01234);
		end
		@(posedge clk_in);
		cpage <= 8'h03;
		tick();
		check(estart, 18'h00c00);
	endtask

	task automatic s_hold();
		@(posedge clk_in);
		ce <= 1'b0;
		sfr_wr(ARM_REG_ADDR, 8'h01);
		tick();
		check(steer, 1'b0);
		@(posedge clk_in);
		ce <= 1'b1;
	endtask

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	initial begin
		rst_in = 1'b1;
		ce = 1'b1;
		irq_en = 1'b0;
		pr_start = 1'b0;
		dbg_en = 1'b1;
		dbg_op = 1'b1;
		dbg_mass = 1'b0;
		lock_set = 1'b0;
		sfr = '0;
		st = '0;
		paddr = 16'h0000;
		bank = '0;
		cpage = 8'h00;
		s_boot();
		s_write();
		s_collide();
		s_erase();
		s_map();
		s_hold();
		tally_and_finish();
	end
endmodule
